// ===== hdl/ebs_cycle_engine.sv
// External bus cycle engine with dynamic bus sizing
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Alignment comes from the byte offset bit; words at odd addresses misalign.
// - At most one aligned word per cycle; long word sends high word first.
// - Core never issues misaligned word or long-word requests.
// - Three-byte code appears only as a long-word remainder to 8-bit port.
// - Byte to 8-bit port: upper lane, copied low on writes, 8-bit ack.
// - Byte to 16-bit port: lane by offset, replicated on writes, 16-bit ack.
// - Aligned word to 16-bit port: both bytes in one cycle.
// - Aligned word to 8-bit port: first byte, then a byte remainder cycle.
// - Long word to 16-bit port: two bytes, then aligned word cycle.
// - Long word to 8-bit port: first byte, then three-byte remainder.
// - Three-byte remainder: next byte, then word remainder cycle.
// - Internal module accesses finish in two clocks, no waits.
// - External cycle at least three clocks; wait until an acknowledge.
// - No own limit on acknowledge wait besides termination.
// - Fast termination finishes external access in three clocks, plus fast waits.
// - Acknowledge, fault and data inputs are registered before use.
// - Read data is latched one clock after acknowledge is seen.
// - Always-on monitor faults the cycle after up to 64 clocks.
// - Fault with halt acts exactly like fault alone.
// - Ack pair: 11 wait, 10 8-bit, 01 16-bit, 00 reserved.
// - Size code gives bytes remaining, valid while address strobe asserted.
module ebs_cycle_engine (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_sys_rst,
  input  wire ebs_pkg::ebs_req_t    i_req,
  input  wire logic                 i_req_valid,
  input  wire logic [6:0]           i_monitor_timeout_sel,
  input  wire logic [1:0]           i_fast_waits,
  input  wire ebs_pkg::ebs_ack_t    i_ack,
  input  wire logic [15:0]          i_data,
  output logic                      o_req_ready,
  output logic                      o_done,
  output logic                      o_fault,
  output logic [31:0]               o_rdata,
  output ebs_pkg::ebs_bus_t         o_bus,
  output logic                      o_address_valid_strobe_n,
  output logic                      o_data_valid_strobe_n,
  output logic                      o_bus_reference_clock
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ebs_pkg::ebs_state_t state_q;
  ebs_pkg::ebs_req_t   req_q;
  logic [31:0]         rem_q;
  logic [1:0]          size_q;
  logic [23:0]         addr_q;
  logic [1:0]          clk_cnt_q;
  logic [1:0]          fwait_q;
  logic [1:0]          ack_q;
  logic                fault_q;
  logic [15:0]         din_q;
  logic [1:0]          port_q;
  logic [31:0]         rdata_q;
  logic [15:0]         lanes;
  logic                timeout;
  logic                ack_seen;
  logic                ext_cycle;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bytes moved given size code and acknowledged port width
  function automatic logic [2:0] bytes_moved(input logic [1:0] sz,
                                             input logic       off,
                                             input logic [1:0] ack);
    logic [2:0] total;
    total = (sz == ebs_pkg::SIZE_LONG) ? 3'h4 : {1'b0, sz};
    if (ack == ebs_pkg::ACK_PORT8 || sz == ebs_pkg::SIZE_BYTE || off) begin
      bytes_moved = 3'h1;
    end else begin
      bytes_moved = (total > 3'h2) ? 3'h2 : total;
    end
  endfunction : bytes_moved

  // Remaining size code after a move
  function automatic logic [1:0] size_after(input logic [1:0] sz,
                                            input logic [2:0] moved);
    logic [2:0] total;
    logic [2:0] left;
    total = (sz == ebs_pkg::SIZE_LONG) ? 3'h4 : {1'b0, sz};
    left  = total - moved;
    size_after = left[1:0];
  endfunction : size_after

  ebs_lane_mux u_lane_mux (
    .i_size   (size_q),
    .i_offset (addr_q[0]),
    .i_rem    (rem_q),
    .o_lanes  (lanes)
  );

  ebs_bus_monitor u_bus_monitor (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_active   (ext_cycle),
    .i_period   (i_monitor_timeout_sel),
    .o_timeout  (timeout)
  );

  assign ext_cycle = (state_q == ebs_pkg::EBS_WAIT) && !req_q.internal;
  // Wait code never terminates; reserved 00 is treated as a wait too
  assign ack_seen  = (ack_q == ebs_pkg::ACK_PORT8) ||
                     (ack_q == ebs_pkg::ACK_PORT16);

  // ----------------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ack_q   <= ebs_pkg::ACK_WAIT;
      fault_q <= 1'b0;
      din_q   <= ebs_pkg::DATA_RESET[15:0];
    end else begin
      ack_q   <= i_ack.port_size_ack_n;
      // Halt with fault is treated as fault alone; halt alone is ignored
      fault_q <= !i_ack.bus_fault_in_n;
      din_q   <= i_data;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q   <= ebs_pkg::EBS_IDLE;
      req_q     <= '0;
      rem_q     <= ebs_pkg::DATA_RESET;
      size_q    <= ebs_pkg::SIZE_BYTE;
      addr_q    <= ebs_pkg::DATA_RESET[23:0];
      clk_cnt_q <= 2'h0;
      fwait_q   <= 2'h0;
      port_q    <= ebs_pkg::ACK_WAIT;
      rdata_q   <= ebs_pkg::DATA_RESET;
      o_done    <= 1'b0;
      o_fault   <= 1'b0;
    end else begin
      o_done  <= 1'b0;
      o_fault <= 1'b0;
      case (state_q)
        ebs_pkg::EBS_IDLE: begin
          // Misaligned word/long requests are not produced by the core
          if (i_req_valid) begin
            req_q     <= i_req;
            rem_q     <= i_req.wdata;
            size_q    <= i_req.size;
            addr_q    <= i_req.addr;
            rdata_q   <= ebs_pkg::DATA_RESET;
            clk_cnt_q <= 2'h1;
            fwait_q   <= i_fast_waits;
            state_q   <= ebs_pkg::EBS_ADDR;
          end
        end
        ebs_pkg::EBS_ADDR: begin
          clk_cnt_q <= (clk_cnt_q == 2'h3) ? clk_cnt_q : clk_cnt_q + 2'h1;
          if (req_q.internal) begin
            // Internal cycles: ack is generated in here
            port_q  <= ebs_pkg::ACK_PORT16;
            state_q <= ebs_pkg::EBS_LATCH;
          end else if (req_q.fast) begin
            // Strobes stand two clocks so the registered data has settled
            if (clk_cnt_q < 2'h2) begin
              state_q <= ebs_pkg::EBS_ADDR;
            end else if (fwait_q != 2'h0) begin
              fwait_q <= fwait_q - 2'h1;
            end else begin
              port_q  <= ebs_pkg::ACK_PORT16;
              state_q <= ebs_pkg::EBS_LATCH;
            end
          end else begin
            state_q <= ebs_pkg::EBS_WAIT;
          end
        end
        ebs_pkg::EBS_WAIT: begin
          if (fault_q || timeout) begin
            o_fault <= 1'b1;
            state_q <= ebs_pkg::EBS_DONE;
          end else if (ack_seen && clk_cnt_q >= 2'h2) begin
            // Three clock minimum: addr, wait, latch
            port_q  <= ack_q;
            state_q <= ebs_pkg::EBS_LATCH;
          end else begin
            clk_cnt_q <= (clk_cnt_q == 2'h3) ? clk_cnt_q : clk_cnt_q + 2'h1;
            // No own limit besides the monitor
            state_q <= ebs_pkg::EBS_WAIT;
          end
        end
        ebs_pkg::EBS_LATCH: begin : latch_blk
          logic [2:0] moved;
          logic [1:0] nsize;
          moved = bytes_moved(size_q, addr_q[0], port_q);
          nsize = size_after(size_q, moved);
          if (!req_q.write) begin
            // Data taken one clock after the ack is recognised
            if (moved == 3'h2) begin
              rdata_q <= {rdata_q[15:0], din_q};
            end else if (addr_q[0] && port_q == ebs_pkg::ACK_PORT16) begin
              rdata_q <= {rdata_q[23:0], din_q[7:0]};
            end else begin
              rdata_q <= {rdata_q[23:0], din_q[15:8]};
            end
          end
          if (moved == 3'h2) begin
            rem_q <= {rem_q[15:0], 16'h0000};
          end else begin
            rem_q <= {rem_q[23:0], 8'h00};
          end
          addr_q <= addr_q + {21'h00_0000, moved};
          if (size_q == ebs_pkg::SIZE_BYTE ||
              (size_q == ebs_pkg::SIZE_WORD && moved == 3'h2)) begin
            state_q <= ebs_pkg::EBS_DONE;
          end else begin
            // Remainder: long->word (16) or long->three->word->byte (8)
            size_q    <= nsize;
            clk_cnt_q <= 2'h1;
            fwait_q   <= i_fast_waits;
            state_q   <= ebs_pkg::EBS_ADDR;
          end
        end
        ebs_pkg::EBS_DONE: begin
          o_done  <= 1'b1;
          state_q <= ebs_pkg::EBS_IDLE;
        end
        default: begin
          state_q <= ebs_pkg::EBS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered bus outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_bus                    <= '{addr: 24'h00_0000, size: 2'h1,
                                    write: 1'b0, data: 16'h0000,
                                    data_oe_n: 16'hFFFF};
      o_address_valid_strobe_n <= 1'b1;
      o_data_valid_strobe_n    <= 1'b1;
      o_req_ready              <= 1'b0;
      o_rdata                  <= ebs_pkg::DATA_RESET;
    end else begin
      o_req_ready <= (state_q == ebs_pkg::EBS_IDLE) && !i_req_valid;
      o_rdata     <= rdata_q;
      if ((state_q == ebs_pkg::EBS_ADDR || state_q == ebs_pkg::EBS_WAIT)
          && !req_q.internal) begin
        o_bus.addr  <= addr_q;
        o_bus.size  <= size_q;
        o_bus.write <= req_q.write;
        o_bus.data  <= lanes;
        o_bus.data_oe_n <= req_q.write ? 16'h0000 : 16'hFFFF;
        o_address_valid_strobe_n <= 1'b0;
        // Fast writes leave the data strobe off
        o_data_valid_strobe_n <= req_q.fast && req_q.write;
      end else begin
        o_bus.data_oe_n          <= 16'hFFFF;
        o_address_valid_strobe_n <= 1'b1;
        o_data_valid_strobe_n    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reference clock: half the core rate, free running
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_bus_reference_clock <= 1'b0;
    end else begin
      o_bus_reference_clock <= !o_bus_reference_clock;
    end
  end
endmodule : ebs_cycle_engine
`default_nettype wire

// ===== hdl/ebs_pkg.sv
// Package for the external bus sizing cycle engine
package ebs_pkg;

  // ----------------------------------------------------------------------
  // Size codes (bytes remaining)
  // ----------------------------------------------------------------------
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // ----------------------------------------------------------------------
  // Port-size acknowledge codes (active low pair)
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACK_WAIT   = 2'h3;
  localparam logic [1:0] ACK_PORT8  = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_RSVD   = 2'h0;

  // ----------------------------------------------------------------------
  // Timing (core clocks, clock period in ns) and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned EXT_MIN_CLKS    = 3;
  localparam int unsigned INT_CLKS        = 2;
  localparam int unsigned FAST_CLKS       = 2;
  localparam int unsigned MON_MAX_CLKS    = 64;
  localparam logic [6:0]  MON_SEL_RESET   = 7'h40;
  localparam logic [6:0]  CNT_W0          = 7'h00;
  localparam logic [31:0] DATA_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    EBS_IDLE  = 3'b000,
    EBS_ADDR  = 3'b001,
    EBS_WAIT  = 3'b010,
    EBS_LATCH = 3'b011,
    EBS_DONE  = 3'b100
  } ebs_state_t;

  // Request from the core
  typedef struct packed {
    logic        write;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic        internal;
    logic        fast;
  } ebs_req_t;

  // Bus outputs of one cycle
  typedef struct packed {
    logic [23:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [15:0] data;
    logic [15:0] data_oe_n;
  } ebs_bus_t;

  // Acknowledge pin group
  typedef struct packed {
    logic [1:0] port_size_ack_n;
    logic       bus_fault_in_n;
    logic       halt_in_n;
  } ebs_ack_t;

endpackage : ebs_pkg

// ===== hdl/ebs_lane_mux.sv
// Byte lane router for one bus cycle
`timescale 1ns/10ps
`default_nettype none
module ebs_lane_mux (
  input  wire logic [1:0]  i_size,
  input  wire logic        i_offset,
  input  wire logic [31:0] i_rem,
  output logic      [15:0] o_lanes
);
  logic [7:0] b0;
  logic [7:0] b1;
  assign b0 = i_rem[31:24];
  assign b1 = i_rem[23:16];

  always_comb begin
    if (i_size == ebs_pkg::SIZE_BYTE) begin
      o_lanes = {b0, b0};
    end else if (i_offset) begin
      o_lanes = {b0, b0};
    end else begin
      o_lanes = {b0, b1};
    end
  end
endmodule : ebs_lane_mux
`default_nettype wire

// ===== hdl/ebs_bus_monitor.sv
// Always-on bus monitor timeout counter
`timescale 1ns/10ps
`default_nettype none
module ebs_bus_monitor (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_active,
  input  wire logic [6:0] i_period,
  output logic            o_timeout
);
  logic [6:0] cnt_q;
  logic [6:0] lim;

  // Zero and values above the cap fall back to the longest period
  assign lim = (i_period == ebs_pkg::CNT_W0 ||
                i_period > ebs_pkg::MON_SEL_RESET) ?
               ebs_pkg::MON_SEL_RESET : i_period;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !i_active) begin
      cnt_q     <= ebs_pkg::CNT_W0;
      o_timeout <= 1'b0;
    end else begin
      cnt_q     <= (cnt_q == lim) ? cnt_q : cnt_q + 7'h01;
      o_timeout <= (cnt_q + 7'h01 >= lim);
    end
  end
endmodule : ebs_bus_monitor
`default_nettype wire

// ===== test/ebs_cycle_engine_assertions.sv
// Concurrent checks on the bus sizing cycle engine ports
`timescale 1ns/10ps
`default_nettype none
module ebs_cycle_engine_assertions (
  input wire logic              i_core_clk,
  input wire logic              i_sys_rst,
  input wire ebs_pkg::ebs_req_t i_req,
  input wire logic              i_req_valid,
  input wire logic [6:0]        i_monitor_timeout_sel,
  input wire ebs_pkg::ebs_ack_t i_ack,
  input wire logic              o_req_ready,
  input wire logic              o_done,
  input wire logic              o_fault,
  input wire ebs_pkg::ebs_bus_t o_bus,
  input wire logic              o_address_valid_strobe_n
);
  // ----
  // Helpers
  // ----
  logic       asn;
  logic       fast_q;
  logic [1:0] last_size_q;
  logic [6:0] low_cnt_q;
  logic [6:0] sel_eff;
  logic       ack_wait;
  assign asn = o_address_valid_strobe_n;
  assign sel_eff = (i_monitor_timeout_sel == 7'h00 ||
                    i_monitor_timeout_sel > 7'h40) ? 7'h40
                                                   : i_monitor_timeout_sel;
  assign ack_wait = i_ack.port_size_ack_n == ebs_pkg::ACK_WAIT &&
                    i_ack.bus_fault_in_n;
  // Internally acknowledged operations ignore the pins
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) fast_q <= 1'b0;
    else if (i_req_valid && o_req_ready)
      fast_q <= i_req.fast | i_req.internal;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || o_done) last_size_q <= ebs_pkg::SIZE_BYTE;
    else if (!asn) last_size_q <= o_bus.size;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || asn) low_cnt_q <= 7'h00;
    else if (low_cnt_q != 7'h7f) low_cnt_q <= low_cnt_q + 7'h01;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ----
  // Properties
  // ----
  property p_hold;
    !asn && !$past(asn) |-> $stable(o_bus.size) && $stable(o_bus.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("size or address moved inside a bus cycle");
  property p_min_len;
    $fell(asn) |=> !asn;
  endproperty
  a_min_len: assert property (p_min_len)
    else $error("bus cycle shorter than two clocks");
  property p_repl;
    !asn && o_bus.write && o_bus.size == ebs_pkg::SIZE_BYTE
      |-> o_bus.data[15:8] == o_bus.data[7:0];
  endproperty
  a_repl: assert property (p_repl)
    else $error("byte write not replicated on both lanes");
  property p_three;
    $fell(asn) && o_bus.size == ebs_pkg::SIZE_THREE
      |-> last_size_q == ebs_pkg::SIZE_LONG;
  endproperty
  a_three: assert property (p_three)
    else $error("three byte code not after a long word cycle");
  property p_after_three;
    $fell(asn) && last_size_q == ebs_pkg::SIZE_THREE
      |-> o_bus.size == ebs_pkg::SIZE_WORD;
  endproperty
  a_after_three: assert property (p_after_three)
    else $error("three byte cycle not followed by word code");
  property p_wait;
    (!asn && !fast_q && ack_wait && low_cnt_q + 7'h04 < sel_eff)[*3]
      |=> !asn;
  endproperty
  a_wait: assert property (p_wait)
    else $error("cycle ended without acknowledge");
  property p_monitor;
    !asn |-> low_cnt_q <= sel_eff + 7'h06;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor let a cycle run past its period");
  property p_internal;
    o_req_ready && i_req_valid && i_req.internal
      |=> asn throughout (1'b1 ##[1:3] o_done);
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal access late or touched the strobes");
  property p_fault_done;
    o_fault |=> o_done;
  endproperty
  a_fault_done: assert property (p_fault_done)
    else $error("aborted cycle not closed next clock");
endmodule : ebs_cycle_engine_assertions

bind ebs_cycle_engine ebs_cycle_engine_assertions ebs_chk_inst (
  .i_core_clk, .i_sys_rst, .i_req, .i_req_valid, .i_monitor_timeout_sel,
  .i_ack, .o_req_ready, .o_done, .o_fault, .o_bus,
  .o_address_valid_strobe_n
);
`default_nettype wire

// ===== test/ebs_port_model.sv
// Far-side memory with an 8-bit or 16-bit port
`timescale 1ns/10ps
`default_nettype none
module ebs_port_model (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire ebs_pkg::ebs_bus_t i_bus,
  input  wire logic              i_as_n,
  input  wire logic              i_port16,
  input  wire logic [2:0]        i_waits,
  input  wire logic [1:0]        i_mode,
  output ebs_pkg::ebs_ack_t      o_ack,
  output logic [15:0]            o_data
);
  logic [7:0] mem [16];
  logic [2:0] cnt_q;
  logic [3:0] a;
  logic [3:0] e;
  logic       wr;
  logic [15:0] idle_q;
  assign a  = i_bus.addr[3:0];
  assign e  = {a[3:1], 1'b0};
  assign wr = i_bus.write;
  // Released bus flips so stale data never looks valid
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_as_n) begin
      cnt_q  <= 3'h0;
      o_ack  <= {ebs_pkg::ACK_WAIT, 2'h3};
      idle_q <= i_sys_rst ? 16'h5a5a : ~idle_q;
    end else if (cnt_q < i_waits) begin
      cnt_q <= cnt_q + 3'h1;
    end else if (i_mode == 2'h1) begin
      o_ack <= {ebs_pkg::ACK_WAIT, 2'h0};
    end else if (i_mode == 2'h3) begin
      o_ack <= {ebs_pkg::ACK_RSVD, 2'h3};
    end else if (i_mode == 2'h0) begin
      o_ack <= {i_port16 ? ebs_pkg::ACK_PORT16
                         : ebs_pkg::ACK_PORT8, 2'h3};
      if (wr && !i_port16) mem[a] <= i_bus.data[15:8];
      else if (wr && i_bus.size == ebs_pkg::SIZE_BYTE)
        mem[a] <= a[0] ? i_bus.data[7:0] : i_bus.data[15:8];
      else if (wr) begin
        mem[e]        <= i_bus.data[15:8];
        mem[e + 4'h1] <= i_bus.data[7:0];
      end
    end
  end
  // Asynchronous memory: read data follows the strobe with no clock,
  // fast enough for chip-select terminated cycles
  always_comb begin
    if (i_as_n || wr) begin
      o_data = idle_q;
    end else if (i_port16) begin
      o_data = {mem[e], mem[e + 4'h1]};
    end else begin
      o_data = {mem[a], ~idle_q[7:0]};
    end
  end
endmodule : ebs_port_model
`default_nettype wire

// ===== test/ebs_cycle_engine_tb.sv
// Self-checking bench for the bus sizing cycle engine
`timescale 1ns/10ps
`default_nettype none
module ebs_cycle_engine_tb;
  logic              clk, rst, vld, rdy, done, flt, as_n, p16, f, asq;
  ebs_pkg::ebs_req_t req;
  ebs_pkg::ebs_ack_t ack;
  ebs_pkg::ebs_bus_t bus;
  logic [6:0]        sel;
  logic [1:0]        fwait, mode;
  logic [2:0]        mw;
  logic [15:0]       din;
  logic [31:0]       rdata, rd;
  logic [7:0]        szl;
  int                n_mismatch, n_compared, nb, cyc;

  ebs_cycle_engine ebs_cycle_engine_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .i_req_valid(vld),
    .i_monitor_timeout_sel(sel), .i_fast_waits(fwait), .i_ack(ack),
    .i_data(din), .o_req_ready(rdy), .o_done(done), .o_fault(flt),
    .o_rdata(rdata), .o_bus(bus), .o_address_valid_strobe_n(as_n),
    .o_data_valid_strobe_n(), .o_bus_reference_clock()
  );
  ebs_port_model ebs_port_model_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus), .i_as_n(as_n),
    .i_port16(p16), .i_waits(mw), .i_mode(mode), .o_ack(ack), .o_data(din)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Log of size codes, one per strobe fall
  always @(posedge clk) begin
    asq <= as_n;
    if (asq && !as_n) begin
      nb++;
      szl = {szl[5:0], bus.size};
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic op(input logic w, input logic [1:0] s,
                    input logic [23:0] ad, input logic [31:0] wd,
                    input logic it, input logic ft);
    int n;
    @(posedge clk);
    req <= '{w, s, ad, wd, it, ft};
    vld <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 200);
    vld <= 1'b0;
    nb = 0;
    szl = 8'h00;
    cyc = 0;
    f = 1'b0;
    do begin
      @(posedge clk);
      cyc++;
      if (flt === 1'b1) f = 1'b1;
    end while (done !== 1'b1 && cyc < 300);
    rd = rdata;
    chk("done", 32'h0000_0001, {31'h0000_0000, done === 1'b1});
  endtask : op

  task automatic t_byte;
    logic [7:0] bv;
    for (int k = 0; k < 4; k++) begin
      bv = 8'hc0 + 8'(k);
      p16 <= k[1];
      op(1'b1, ebs_pkg::SIZE_BYTE, {23'h00_0008, k[0]}, {bv, 24'h00_0000},
         1'b0, 1'b0);
      chk("byte store", {24'h00_0000, bv},
          {24'h00_0000, ebs_port_model_inst.mem[k[0]]});
      op(1'b0, ebs_pkg::SIZE_BYTE, {23'h00_0008, k[0]}, 32'h0000_0000,
         1'b0, 1'b0);
      chk("byte load", {24'h00_0000, bv}, rd);
      chk("byte cycles", 32'h0000_0101, {nb[23:0], szl});
    end
    $display("byte test finished");
  endtask : t_byte

  task automatic t_multi;
    logic [15:0] exp_c [4] = '{16'h0439, 16'h0202, 16'h0209, 16'h0102};
    logic [31:0] wd;
    logic [1:0]  sz;
    for (int k = 0; k < 4; k++) begin
      p16 <= k[0];
      sz = k[1] ? ebs_pkg::SIZE_WORD : ebs_pkg::SIZE_LONG;
      wd = k[1] ? 32'hc3d4_0000 : 32'h1122_3344;
      op(1'b1, sz, 24'h00_0024, wd, 1'b0, 1'b0);
      chk("store", {wd[31:16], 16'h3344}, {ebs_port_model_inst.mem[4],
          ebs_port_model_inst.mem[5], ebs_port_model_inst.mem[6],
          ebs_port_model_inst.mem[7]});
      op(1'b0, sz, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
      chk("load", k[1] ? {16'h0000, wd[31:16]} : wd, rd);
      chk("cycle codes", {16'h0000, exp_c[k]}, {nb[23:0], szl});
    end
    $display("width test finished");
  endtask : t_multi

  task automatic t_timing;
    int c0;
    p16 <= 1'b1;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
    c0 = cyc;
    mw <= 3'h3;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
    chk("wait stretch", c0 + 3, cyc);
    mw <= 3'h0;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b1, 1'b0);
    chk("internal", 32'h0000_0001, {31'h0, nb == 0 && cyc < c0});
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b1);
    c0 = cyc;
    // Last word store of the width test left 8'hc3 at this address
    chk("fast data", 32'h0000_00c3, rd);
    @(posedge clk);
    fwait <= 2'h2;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b1);
    chk("fast waits", c0 + 2, cyc);
    fwait <= 2'h0;
    $display("timing test finished");
  endtask : t_timing

  task automatic t_fault;
    mode <= 2'h1;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
    chk("fault with halt", 32'h0000_0001, {31'h0, f});
    mode <= 2'h3;
    @(posedge clk);
    sel <= 7'h10;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
    chk("reserved ack", 32'h0000_0001, {31'h0, f && cyc >= 16});
    mode <= 2'h2;
    @(posedge clk);
    sel <= 7'h00;
    op(1'b0, ebs_pkg::SIZE_BYTE, 24'h00_0024, 32'h0000_0000, 1'b0, 1'b0);
    chk("monitor", 32'h0000_0001,
        {31'h0, f && cyc >= 64 && cyc < 80});
    mode <= 2'h0;
    $display("fault test finished");
  endtask : t_fault

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    rst = 1'b1;
    vld = 1'b0;
    req = '0;
    sel = 7'h40;
    fwait = 2'h0;
    p16 = 1'b1;
    mw = 3'h0;
    mode = 2'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_byte;
    t_multi;
    t_timing;
    t_fault;
    end_sim;
  end
  initial begin
    #(8 * 20000);
    n_mismatch++;
    $display("BAD watchdog expected finish seen hang");
    end_sim;
  end
endmodule : ebs_cycle_engine_tb
`default_nettype wire
